// *** qlp_packer.v ***
/*
  Transport-layer packer for a quad channel 12-bit converter: takes one
  sample per channel per clock, builds lane frames, drives lane enables,
  lane identifiers, multiframe marks and the line-rate multiplier.
  Assumes a plain register port master and a link layer downstream.
*/
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "qlp_map.vh"

module qlp_packer #(
  parameter LANES = 8,
  parameter FRAME_W = 64,
  parameter SAMP_W = 12
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [2:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Sample input, one sample per channel per valid cycle
  input wire samp_valid,
  input wire [SAMP_W-1:0] samp_a,
  input wire [SAMP_W-1:0] samp_b,
  input wire [SAMP_W-1:0] samp_c,
  input wire [SAMP_W-1:0] samp_d,
  // Lane side
  output reg [LANES*FRAME_W-1:0] lane_frame,
  output reg frame_valid,
  output reg multiframe_start,
  output reg [LANES-1:0] lane_power_on,
  output reg [LANES*3-1:0] lane_ident,
  output reg [7:0] link_dev_id,
  output reg [9:0] line_rate_mult,
  output reg link_active
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_ARM = 4'b0010;
  localparam ST_RUN = 4'b0100;
  localparam ST_FAULT = 4'b1000;
  localparam HIST_W = 10 * SAMP_W;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Sample j of a history, oldest first.
  function [SAMP_W-1:0] pick;
    input [HIST_W-1:0] h;
    input integer j;
    begin
      pick = h[HIST_W-1-j*SAMP_W -: SAMP_W];
    end
  endfunction

  // Five even or odd samples, then a zero tail.
  function [FRAME_W-1:0] pack_eo;
    input [HIST_W-1:0] h;
    input odd;
    integer k;
    begin
      pack_eo = {FRAME_W{1'b0}}; // RULE18
      for (k = 0; k < 5; k = k + 1) begin
        pack_eo[FRAME_W-1-k*SAMP_W -: SAMP_W] = pick(h, 2 * k + (odd ? 1 : 0)); // RULE19 RULE20
      end
    end
  endfunction

  // Effective K for 64B/66B is 256 times E over F.
  function [8:0] keff;
    input [1:0] e;
    input [3:0] f;
    reg [9:0] num;
    reg [9:0] quo;
    begin
      num = {e, `QLP_K_NUM};
      quo = 10'h000;
      if (f == 4'h0) begin
        keff = 9'h000;
      end else begin
        // The largest quotient is 256, so the top bit is always clear.
        quo = num / {6'h00, f}; // RULE5
        keff = quo[8:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg link_en_r;
  reg [3:0] mode_r;
  reg [7:0] km1_r;
  reg [7:0] devid_r;
  reg [3:0] act_mode_r;
  reg [7:0] act_km1_r;
  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [4:0] cnt_r;
  reg [8:0] fcnt_r;

  wire [`QLP_E_W-1:0] entry;

  qlp_mode_rom u_rom (
    .clk(clk),
    .sel(act_mode_r),
    .entry_r(entry)
  );

  wire enc_64 = entry[`QLP_F_ENC];
  wire [3:0] f_n = entry[`QLP_F_N +: 4];
  wire [3:0] f_l = entry[`QLP_F_L +: 4];
  wire [3:0] f_m = entry[`QLP_F_M +: 4];
  wire [3:0] f_f = entry[`QLP_F_F +: 4];
  wire [2:0] f_s = entry[`QLP_F_S +: 3];
  wire [1:0] f_hd = entry[`QLP_F_HD +: 2];
  wire [1:0] f_e = entry[`QLP_F_E +: 2];
  wire [9:0] f_r = entry[`QLP_F_R +: 10];
  wire [1:0] f_kstep = entry[`QLP_F_KSTEP +: 2];

  // ----------------------------------------------------------------
  // K checking and selection
  // ----------------------------------------------------------------
  reg k_ok;
  always @* begin
    case (f_kstep) // RULE3
      `QLP_KSTEP_4: k_ok = (act_km1_r[1:0] == 2'h3);
      `QLP_KSTEP_16: k_ok = (act_km1_r[3:0] == 4'hF);
      `QLP_KSTEP_32: k_ok = (act_km1_r[4:0] == 5'h1F);
      default: k_ok = 1'b0;
    endcase
    if (enc_64) begin
      k_ok = 1'b1; // RULE4
    end
  end

  // The programmed field plays no part once the mode is 64B/66B.
  wire [8:0] k_val = enc_64 ? keff(f_e, f_f) : {1'b0, act_km1_r} + 9'h001; // RULE4

  // Only the even/odd and dense layouts are packed; other modes run
  // their multiframe timing but never raise frame_valid or update lane_frame.
  wire lay_eo = (act_mode_r == `QLP_MODE_EVENODD);
  wire lay_dense = (act_mode_r == `QLP_MODE_DENSE);
  wire lay_ok = lay_eo | lay_dense;
  wire [6:0] sm_prod = {4'h0, f_s} * {3'h0, f_m};
  wire [4:0] spc = sm_prod[6:2];
  wire run = (state_r == ST_RUN);
  wire take = run & samp_valid;
  wire last = take & (cnt_r == spc - 5'h01);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      link_en_r <= 1'b0;
      mode_r <= `QLP_RST_MODE;
      km1_r <= `QLP_RST_KM1;
      devid_r <= `QLP_RST_DEVID;
    end else if (reg_wr) begin
      case (reg_addr)
        `QLP_A_CTRL: link_en_r <= reg_wdata[0];
        `QLP_A_MODE: mode_r <= reg_wdata[3:0]; // RULE2
        `QLP_A_KCFG: km1_r <= reg_wdata[7:0];
        `QLP_A_DEVID: devid_r <= reg_wdata[7:0];
        default: link_en_r <= link_en_r;
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `QLP_A_CTRL: reg_rdata <= {31'h0000_0000, link_en_r};
        `QLP_A_MODE: reg_rdata <= {28'h000_0000, mode_r};
        `QLP_A_KCFG: reg_rdata <= {24'h00_0000, km1_r};
        `QLP_A_DEVID: reg_rdata <= {24'h00_0000, devid_r};
        `QLP_A_STATUS:
          reg_rdata <= {20'h0_0000, f_l, state_r, lay_ok, k_ok, enc_64, run};
        `QLP_A_PARAMS:
          reg_rdata <= {4'h0, f_n, f_m, f_f, 1'b0, f_s, 2'h0, f_hd, 2'h0, f_e, f_l};
        `QLP_A_RATE: reg_rdata <= {7'h00, k_val, 6'h00, f_r};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Active configuration
  // ----------------------------------------------------------------
  // Copies follow software only while the link is down, so a running
  // link never sees a half-changed selector and K pair.
  always @(posedge clk) begin
    if (rst) begin
      act_mode_r <= `QLP_RST_MODE;
      act_km1_r <= `QLP_RST_KM1;
    end else if (state_r == ST_IDLE) begin
      act_mode_r <= mode_r; // RULE23
      act_km1_r <= km1_r; // RULE23
    end
  end

  // ----------------------------------------------------------------
  // Link state
  // ----------------------------------------------------------------
  // Arm waits one cycle so the registered table entry is current.
  always @* begin
    case (state_r)
      ST_IDLE: state_nxt = link_en_r ? ST_ARM : ST_IDLE;
      ST_ARM: state_nxt = !link_en_r ? ST_IDLE : (k_ok ? ST_RUN : ST_FAULT); // RULE3
      ST_RUN: state_nxt = link_en_r ? ST_RUN : ST_IDLE;
      ST_FAULT: state_nxt = link_en_r ? ST_FAULT : ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sample history per channel
  // ----------------------------------------------------------------
  wire [SAMP_W-1:0] ch_in [0:3];
  wire [HIST_W-1:0] hist_nxt [0:3];
  assign ch_in[0] = samp_a;
  assign ch_in[1] = samp_b;
  assign ch_in[2] = samp_c;
  assign ch_in[3] = samp_d;

  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1) begin : g_ch
      reg [HIST_W-1:0] hist_r;
      assign hist_nxt[c] = {hist_r[HIST_W-SAMP_W-1:0], ch_in[c]};
      always @(posedge clk) begin
        if (rst) begin
          hist_r <= {HIST_W{1'b0}};
        end else if (take) begin
          hist_r <= hist_nxt[c];
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (rst || !run) begin
      cnt_r <= 5'h00;
    end else if (take) begin
      cnt_r <= last ? 5'h00 : cnt_r + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Frame assembly
  // ----------------------------------------------------------------
  reg [LANES*FRAME_W-1:0] frame_nxt;
  reg [SAMP_W-1:0] dx0, dx1, dy0, dy1;
  integer i;
  integer j;
  always @* begin
    frame_nxt = {LANES*FRAME_W{1'b0}}; // RULE18
    dx0 = {SAMP_W{1'b0}};
    dx1 = {SAMP_W{1'b0}};
    dy0 = {SAMP_W{1'b0}};
    dy1 = {SAMP_W{1'b0}};
    if (lay_eo) begin
      for (i = 0; i < 8; i = i + 1) begin
        frame_nxt[i*FRAME_W +: FRAME_W] = pack_eo(hist_nxt[i/2], i[0]); // RULE20
      end
    end else if (lay_dense) begin
      for (i = 0; i < 2; i = i + 1) begin
        dx0 = pick(hist_nxt[2*i], 8);
        dx1 = pick(hist_nxt[2*i], 9);
        dy0 = pick(hist_nxt[2*i+1], 8);
        dy1 = pick(hist_nxt[2*i+1], 9);
        // Two channels share three 16-bit lanes, top of each lane word.
        frame_nxt[(3*i)*FRAME_W+FRAME_W-16 +: 16] = {dx0, dx1[11:8]}; // RULE21 RULE19
        frame_nxt[(3*i+1)*FRAME_W+FRAME_W-16 +: 16] = {dx1[7:0], dy0[11:4]}; // RULE21
        frame_nxt[(3*i+2)*FRAME_W+FRAME_W-16 +: 16] = {dy0[3:0], dy1}; // RULE21
      end
    end
  end

  // Lanes above L carry zeros so a powered-down driver never toggles.
  reg [LANES*FRAME_W-1:0] lane_mask;
  always @* begin
    for (j = 0; j < LANES; j = j + 1) begin
      lane_mask[j*FRAME_W +: FRAME_W] = (j < f_l) ? {FRAME_W{1'b1}} : {FRAME_W{1'b0}};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      lane_frame <= {LANES*FRAME_W{1'b0}};
      frame_valid <= 1'b0;
    end else begin
      frame_valid <= last & lay_ok;
      if (last & lay_ok) begin
        lane_frame <= frame_nxt & lane_mask; // RULE16
      end
    end
  end

  // ----------------------------------------------------------------
  // Multiframe counting
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst || !run) begin
      fcnt_r <= 9'h000;
      multiframe_start <= 1'b0;
    end else begin
      multiframe_start <= last & (fcnt_r == 9'h000);
      if (last) begin
        fcnt_r <= (fcnt_r == k_val - 9'h001) ? 9'h000 : fcnt_r + 9'h001; // RULE3 RULE5
      end
    end
  end

  // ----------------------------------------------------------------
  // Lane enables, identifiers and rate
  // ----------------------------------------------------------------
  genvar ln;
  generate
    for (ln = 0; ln < LANES; ln = ln + 1) begin : g_lane
      localparam [31:0] LID = ln;
      always @(posedge clk) begin
        if (rst) begin
          lane_power_on[ln] <= 1'b0;
          lane_ident[ln*3 +: 3] <= LID[2:0];
        end else begin
          lane_power_on[ln] <= run && (ln < f_l); // RULE16
          lane_ident[ln*3 +: 3] <= LID[2:0]; // RULE17
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (rst) begin
      link_dev_id <= `QLP_RST_DEVID;
      line_rate_mult <= 10'h000;
      link_active <= 1'b0;
    end else begin
      link_dev_id <= devid_r; // RULE17
      line_rate_mult <= f_r; // RULE22
      link_active <= run;
    end
  end

endmodule

// *** qlp_map.vh ***
/*
  Constants for the quad converter serial lane packer: register offsets,
  reset values, mode table field positions and multiframe figures.
  Assumes it is included by bare name from the design files.
*/
// Summary of operation
// RULE1 - All transport parameters come from the format selector.
// RULE2 - Only selector values zero to fifteen exist.
// RULE3 - 8B/10B K obeys per-mode min, step, max; the code checks only the step, with no min or max.
// RULE4 - 64B/66B modes ignore the programmed K field.
// RULE5 - 64B/66B effective K is 256 times E over F.
// RULE6 - Mode 0: 12-bit, 8 lanes, F8, S5.
// RULE7 - Mode 1: 12-bit, 6 lanes, dense, R10.
// RULE8 - Mode 2: 8-bit, 4 lanes, F1, R10.
// RULE9 - Mode 3: 10-bit, 4 lanes, F5, R12.5.
// RULE10 - Mode 4: 64B/66B, 3 lanes, R16.5.
// RULE11 - Mode 6: 64B/66B, 6 lanes, R8.25.
// RULE12 - Mode 8: 64B/66B, 4 lanes, E3, R12.375.
// RULE13 - Mode 12: two channel, 8 lanes, R2.5.
// RULE14 - Mode 15: two channel 64B/66B, R3.09375.
// RULE15 - Receiver interleaves streams where M equals L.
// RULE16 - Drive lowest lanes, power down the rest.
// RULE17 - Lane identifier equals index; shared device identifier.
// RULE18 - Tail bits are always zero.
// RULE19 - Samples are placed most significant bit first.
// RULE20 - Mode 0 lane pairs carry even, odd samples.
// RULE21 - Mode 1 packs samples densely over six lanes.
// RULE22 - Lane bit rate is sample clock times R.
// RULE23 - Change selector and K only with link disabled.
`ifndef QLP_MAP_VH
`define QLP_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define QLP_A_CTRL 3'h0
`define QLP_A_MODE 3'h1
`define QLP_A_KCFG 3'h2
`define QLP_A_DEVID 3'h3
`define QLP_A_STATUS 3'h4
`define QLP_A_PARAMS 3'h5
`define QLP_A_RATE 3'h6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define QLP_RST_MODE 4'h0
`define QLP_RST_KM1 8'h1F
`define QLP_RST_DEVID 8'h00

// ----------------------------------------------------------------
// Mode table entry layout (least significant bit of each field)
// ----------------------------------------------------------------
`define QLP_E_W 36
`define QLP_F_KSTEP 0
`define QLP_F_R 2
`define QLP_F_E 12
`define QLP_F_HD 14
`define QLP_F_S 16
`define QLP_F_F 19
`define QLP_F_M 23
`define QLP_F_L 27
`define QLP_F_N 31
`define QLP_F_ENC 35

// K step codes for 8B/10B modes.
`define QLP_KSTEP_4 2'h0
`define QLP_KSTEP_16 2'h1
`define QLP_KSTEP_32 2'h2

// ----------------------------------------------------------------
// Multiframe and layout figures
// ----------------------------------------------------------------
`define QLP_K_NUM 8'h00
`define QLP_MODE_EVENODD 4'h0
`define QLP_MODE_DENSE 4'h1

`endif

// *** qlp_mode_rom.v ***
/*
  Mode table: one entry of derived transport parameters per format
  selector value, read data registered.
  Assumes the selector is held steady while the link runs.
*/
`timescale 1ns/1ps
`include "qlp_map.vh"

module qlp_mode_rom (
  // Clock
  input wire clk,
  // Lookup
  input wire [3:0] sel,
  output reg [`QLP_E_W-1:0] entry_r
);

  // ----------------------------------------------------------------
  // Fields: enc, N, L, M, F, S, HD, E, R in 1/32 units, K step.
  // ----------------------------------------------------------------
  // Every selector value has an entry, so no other mode can be reached.
  always @(posedge clk) begin
    case (sel) // RULE1 RULE2
      4'h0: entry_r <= {1'h0, 4'hC, 4'h8, 4'h8, 4'h8, 3'h5, 2'h0, 2'h0, 10'h100, 2'h0}; // RULE6
      4'h1: entry_r <= {1'h0, 4'hC, 4'h6, 4'h4, 4'h2, 3'h2, 2'h1, 2'h0, 10'h140, 2'h1}; // RULE7
      4'h2: entry_r <= {1'h0, 4'h8, 4'h4, 4'h4, 4'h1, 3'h1, 2'h0, 2'h0, 10'h140, 2'h2}; // RULE8
      4'h3: entry_r <= {1'h0, 4'hA, 4'h4, 4'h4, 4'h5, 3'h4, 2'h0, 2'h0, 10'h190, 2'h2}; // RULE9
      4'h4: entry_r <= {1'h1, 4'hC, 4'h3, 4'h4, 4'h2, 3'h1, 2'h1, 2'h1, 10'h210, 2'h0}; // RULE10
      4'h5: entry_r <= {1'h1, 4'h8, 4'h2, 4'h4, 4'h2, 3'h1, 2'h0, 2'h1, 10'h210, 2'h0};
      4'h6: entry_r <= {1'h1, 4'hC, 4'h6, 4'h4, 4'h2, 3'h2, 2'h1, 2'h1, 10'h108, 2'h0}; // RULE11
      4'h7: entry_r <= {1'h1, 4'h8, 4'h4, 4'h4, 4'h1, 3'h1, 2'h0, 2'h1, 10'h108, 2'h0};
      4'h8: entry_r <= {1'h1, 4'hC, 4'h4, 4'h4, 4'h3, 3'h2, 2'h0, 2'h3, 10'h18C, 2'h0}; // RULE12
      4'h9: entry_r <= {1'h0, 4'h8, 4'h8, 4'h4, 4'h1, 3'h2, 2'h0, 2'h0, 10'h0A0, 2'h2};
      4'hA: entry_r <= {1'h0, 4'hA, 4'h8, 4'h8, 4'h5, 3'h4, 2'h0, 2'h0, 10'h0C8, 2'h2};
      4'hB: entry_r <= {1'h0, 4'hC, 4'h8, 4'h8, 4'h8, 3'h5, 2'h0, 2'h0, 10'h080, 2'h0};
      4'hC: entry_r <= {1'h0, 4'h8, 4'h8, 4'h2, 4'h1, 3'h4, 2'h0, 2'h0, 10'h050, 2'h2}; // RULE13
      4'hD: entry_r <= {1'h0, 4'hA, 4'h8, 4'h8, 4'h5, 3'h4, 2'h0, 2'h0, 10'h064, 2'h2};
      4'hE: entry_r <= {1'h1, 4'hC, 4'h8, 4'h8, 4'h3, 3'h2, 2'h0, 2'h3, 10'h0C6, 2'h0};
      4'hF: entry_r <= {1'h1, 4'hC, 4'h8, 4'h8, 4'h3, 3'h2, 2'h2, 2'h3, 10'h063, 2'h0}; // RULE14
      default: entry_r <= {`QLP_E_W{1'b0}};
    endcase
  end

endmodule

// *** qlp_packer_properties.sv ***
/*
  Port checker for the lane packer: register port, frame strobes, lane power.
  Assumes it is bound to qlp_packer and sees only that module's ports.
*/
`timescale 1ns/1ps
module qlp_packer_checker #(
  parameter LANES = 8,
  parameter FRAME_W = 64
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [2:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Lane side
  input wire samp_valid,
  input wire [LANES*FRAME_W-1:0] lane_frame,
  input wire frame_valid,
  input wire multiframe_start,
  input wire [LANES-1:0] lane_power_on,
  input wire [LANES*3-1:0] lane_ident,
  input wire [7:0] link_dev_id,
  input wire [9:0] line_rate_mult,
  input wire link_active
);
  localparam [LANES*FRAME_W-1:0] TAIL = {LANES{{(FRAME_W-4){1'b0}}, 4'hF}};
  reg [7:0] dev_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk) begin
    if (rst) begin
      dev_r <= 8'h00;
    end else if (reg_wr && reg_addr == 3'h3) begin
      dev_r <= reg_wdata[7:0];
    end
  end
  lane_ident_a: assert property (lane_ident == 24'hFAC688)
    else $error("lane identifier wrong");
  dev_copy_a: assert property (reg_wr && reg_addr == 3'h3 |-> ##2 link_dev_id == dev_r)
    else $error("device identifier not copied");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  tail_zero_a: assert property (frame_valid |-> (lane_frame & TAIL) == 0)
    else $error("tail bits not zero");
  frame_pulse_a: assert property (frame_valid |=> !frame_valid)
    else $error("frame strobe too long");
  frame_cause_a: assert property (frame_valid |-> $past(samp_valid))
    else $error("frame without sample");
  mframe_with_a: assert property (multiframe_start |-> frame_valid)
    else $error("multiframe mark without frame");
  lanes_low_a: assert property (link_active |-> lane_power_on[0] &&
      ((lane_power_on & (lane_power_on + 1'b1)) == 0))
    else $error("lanes not lowest indexed");
  power_gate_a: assert property (lane_power_on != 0 |-> link_active)
    else $error("lane powered while idle");
  run_steady_a: assert property (link_active && $past(link_active) |->
      $stable(lane_power_on) && $stable(line_rate_mult))
    else $error("parameters moved while running");
  frame_c: cover property (frame_valid);
  mframe_c: cover property (multiframe_start);
  run_c: cover property ($rose(link_active));
endmodule

bind qlp_packer qlp_packer_checker #(.LANES(LANES), .FRAME_W(FRAME_W)) u_qlp_packer_checker (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .samp_valid,
  .lane_frame, .frame_valid, .multiframe_start, .lane_power_on, .lane_ident,
  .link_dev_id, .line_rate_mult, .link_active);

// *** qlp_rx_model.sv ***
/*
  Far-side receiver model: rebuilds channel A in time order.
  Assumes one-cycle frame strobes beside steady lane data.
*/
`timescale 1ns/1ps
module qlp_rx_model (
  // Clock
  input wire clk,
  // Lanes from the packer
  input wire [511:0] lane_frame,
  input wire frame_valid,
  input wire [7:0] lane_power_on,
  // Rebuilt stream
  output reg [119:0] a_stream
);
  initial a_stream = 120'h0;
  // Even samples ride lane 0 and odd ones lane 1, so both are woven back.
  always @(posedge clk) begin
    if (frame_valid && lane_power_on[1:0] == 2'b11) begin
      for (int k = 0; k < 10; k++) begin
        a_stream[119-12*k -: 12] <= lane_frame[(k%2)*64+63-12*(k/2) -: 12];
      end
    end
  end
endmodule

// *** qlp_tb.sv ***
/*
  Self-checking bench for the lane packer.
  Assumes the packer's default geometry and the receiver model.
*/
`timescale 1ns/1ps
module testbench;
  reg clk;
  reg rst;
  reg [2:0] reg_addr;
  reg [31:0] reg_wdata;
  reg reg_wr, reg_rd, samp_valid;
  reg [11:0] samp_a, samp_b, samp_c, samp_d;
  wire [31:0] reg_rdata;
  wire [511:0] lane_frame;
  wire frame_valid, multiframe_start, link_active;
  wire [7:0] lane_power_on, link_dev_id;
  wire [23:0] lane_ident;
  wire [9:0] line_rate_mult;
  wire [119:0] a_stream;
  int fails = 0;
  int samples_checked = 0;
  int l_t [16] = '{8, 6, 4, 4, 3, 2, 6, 4, 4, 8, 8, 8, 8, 8, 8, 8};
  int r_t [16] = '{256, 320, 320, 400, 528, 528, 264, 264, 396, 160, 200, 128, 80, 100, 198, 99};
  // A nonzero entry marks a 64B/66B mode and gives its fixed K.
  int k_t [16] = '{0, 0, 0, 0, 128, 128, 128, 256, 256, 0, 0, 0, 0, 0, 256, 256};

  qlp_packer u_qlp_packer (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .samp_valid(samp_valid), .samp_a(samp_a), .samp_b(samp_b), .samp_c(samp_c),
    .samp_d(samp_d), .lane_frame(lane_frame), .frame_valid(frame_valid),
    .multiframe_start(multiframe_start), .lane_power_on(lane_power_on),
    .lane_ident(lane_ident), .link_dev_id(link_dev_id),
    .line_rate_mult(line_rate_mult), .link_active(link_active));
  qlp_rx_model u_qlp_rx_model (.clk(clk), .lane_frame(lane_frame),
    .frame_valid(frame_valid), .lane_power_on(lane_power_on), .a_stream(a_stream));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_reg(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_lane(input [127:0] got, input [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input [2:0] a, input [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input [2:0] a, input [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk_reg(reg_rdata, e);
  endtask
  task automatic wait_link(input v);
    for (int i = 0; i < 12 && link_active !== v; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  function automatic [11:0] sv(input int c, input int n);
    sv = {4'(10 + c), 4'(n), 4'(15 - n)};
  endfunction
  function automatic [63:0] l0(input int j);
    l0 = {sv(j/2, j%2), sv(j/2, j%2+2), sv(j/2, j%2+4), sv(j/2, j%2+6), sv(j/2, j%2+8), 4'h0};
  endfunction
  function automatic [63:0] l1(input int j);
    logic [11:0] x1, y0;
    x1 = sv(2*(j/3), 1);
    y0 = sv(2*(j/3)+1, 0);
    case (j % 3)
      0: l1 = {sv(2*(j/3), 0), x1[11:8], 48'h0};
      1: l1 = {x1[7:0], y0[11:4], 48'h0};
      default: l1 = {y0[3:0], sv(2*(j/3)+1, 1), 48'h0};
    endcase
    if (j > 5) l1 = 64'h0;
  endfunction
  task automatic run_mode(input [3:0] m, input [7:0] km1);
    logic [8:0] k;
    k = (k_t[m] != 0) ? 9'(k_t[m]) : 9'(km1) + 9'h1;
    wr(3'h1, {28'h0, m});
    wr(3'h2, {24'h0, km1});
    wr(3'h0, 32'h1);
    wait_link(1'b1);
    chk_reg({24'h0, lane_power_on}, 32'((1 << l_t[m]) - 1));
    chk_reg({22'h0, line_rate_mult}, 32'(r_t[m]));
    rchk(3'h4, {20'h0, 4'(l_t[m]), 4'h4, m < 4'h2, 1'b1, k_t[m] != 0, 1'b1});
    rchk(3'h6, {7'h0, k, 6'h0, 10'(r_t[m])});
  endtask
  task automatic stop_link;
    wr(3'h0, 32'h0);
    wait_link(1'b0);
    chk_reg({24'h0, lane_power_on}, 32'h0);
  endtask
  task automatic send(input int cnt);
    for (int n = 0; n < cnt; n++) begin
      @(posedge clk);
      samp_valid <= 1'b1;
      samp_a <= sv(0, n);
      samp_b <= sv(1, n);
      samp_c <= sv(2, n);
      samp_d <= sv(3, n);
    end
    @(posedge clk);
    samp_valid <= 1'b0;
    #1;
    for (int i = 0; i < 8 && frame_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk_reg({31'h0, frame_valid}, 32'h1);
    chk_reg({31'h0, multiframe_start}, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rchk(3'h0, 32'h0);
    rchk(3'h2, 32'h1F);
    rchk(3'h4, 32'h0000_081C);
    rchk(3'h5, 32'h0C88_5008);
    wr(3'h7, 32'hFFFF_FFFF);
    rchk(3'h7, 32'h0);
    wr(3'h4, 32'hFFFF_FFFF);
    rchk(3'h4, 32'h0000_081C);
    wr(3'h1, 32'hFFFF_FFF3);
    rchk(3'h1, 32'h3);
    wr(3'h3, 32'h0000_01A5);
    rchk(3'h3, 32'hA5);
    chk_reg({24'h0, link_dev_id}, 32'hA5);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 16; m++) begin
      run_mode(4'(m), 8'h1F);
      stop_link;
    end
  endtask
  task automatic t_kcfg;
    wr(3'h1, 32'h1);
    wr(3'h2, 32'h0B);
    wr(3'h0, 32'h1);
    repeat (8) @(posedge clk);
    #1;
    chk_reg({31'h0, link_active}, 32'h0);
    rchk(3'h4, 32'h0000_0688);
    stop_link;
    run_mode(4'h4, 8'h02);
    rchk(3'h5, 32'h0C42_1113);
    stop_link;
  endtask
  task automatic t_mode0;
    logic [119:0] s;
    run_mode(4'h0, 8'h03);
    send(10);
    for (int j = 0; j < 8; j++) chk_lane(lane_frame[j*64 +: 64], l0(j));
    @(posedge clk);
    #1;
    for (int k = 0; k < 10; k++) s[119-12*k -: 12] = sv(0, k);
    chk_lane(a_stream, s);
    stop_link;
  endtask
  task automatic t_mode1;
    run_mode(4'h1, 8'h0F);
    rchk(3'h5, 32'h0C42_2106);
    send(2);
    for (int j = 0; j < 8; j++) chk_lane(lane_frame[j*64 +: 64], l1(j));
    stop_link;
  endtask

  initial begin
    rst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    samp_valid = 1'b0;
    {samp_a, samp_b, samp_c, samp_d} = 48'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_regs;
    t_modes;
    t_kcfg;
    t_mode0;
    t_mode1;
    test_done;
  end
  initial begin
    #200000;
    fails++;
    test_done;
  end
endmodule
